// ---- src/rtu_params.svh ----
// timing, framing and encoding constants of the rtu frame handler
`ifndef RTU_PARAMS_SVH
`define RTU_PARAMS_SVH
// -----------------------------------------------------------------
// clock and bit timebase
// -----------------------------------------------------------------
`define CLK_HZ 20000000
`define BAUD_DEFAULT 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_DEFAULT)
// start, eight data, parity, stop
`define CHAR_BITS 11
// -----------------------------------------------------------------
// gaps, in tenths of a character time, and as bit ticks
// -----------------------------------------------------------------
`define GAP_ABORT_TENTHS 15
`define GAP_FRAME_TENTHS 35
`define GAP_ABORT_TICKS ((`GAP_ABORT_TENTHS * `CHAR_BITS + 9) / 10)
`define GAP_FRAME_TICKS ((`GAP_FRAME_TENTHS * `CHAR_BITS + 9) / 10)
// -----------------------------------------------------------------
// frame fields
// -----------------------------------------------------------------
`define CRC_SEED 16'hFFFF
`define CRC_POLY 16'hA001
`define CMD_READ 8'h03
`define CMD_WRITE 8'h06
`define CMD_LOOP 8'h08
`define ADDR_BCAST 8'h00
`define ADDR_LAST 8'hF7
`define MAX_READ_WORDS 12
`define REQ_LEN 8
`define MIN_FRAME_LEN 4
`define FRAME_MAX 32
`define TXF_DEPTH 32
`endif

// ---- src/rtu_pkg.sv ----
// types shared by the rtu frame handler
package rtu_pkg;
  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_EVAL  = 8'b0000_0010,
    S_FETCH = 8'b0000_0100,
    S_FWAIT = 8'b0000_1000,
    S_FCAP  = 8'b0001_0000,
    S_EMIT  = 8'b0010_0000,
    S_TXW   = 8'b0100_0000,
    S_GAP   = 8'b1000_0000
  } state_t;
endpackage : rtu_pkg

// ---- src/modbus_rtu_slave_frame_handler.sv ----
// rtu slave frame handler with its transmit fifo
// What this block does
// - idle over 1.5 char mid-frame drops partial frame; next byte is address
// - bytes within 1.5 char of a frame join it, failing its CRC
// - 3.5 char silence before and after every frame; here a frame may also start after 1.5 char, following a dropped partial frame
// - character: start, eight data, parity, stop bits
// - half duplex; slave drives only while master listens
// - own address 1..247; accept only frames whose first byte matches
// - address zero is broadcast; only a write is acted upon, without reply
// - field order: address, command, data, two CRC bytes
// - first byte decides whether the frame is for us
// - command 03 reads, 06 writes one word, 08 loops back
// - read of up to 12 words supported
// - format 0: two-byte byte count ahead of data words
// - format 1: one-byte byte count, words high byte first
// - write request and reply: address, 06, address, value, CRC
// - CRC ends frame, low byte first
// - CRC-16 preset FFFF, shift right, xor A001 on carry
// - recompute CRC on receive; mismatch raises an error
`include "rtu_params.svh"

module tx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `TXF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic empty_out
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt;
  logic [W-1:0] od_r, od_nxt;
  logic wr, ld;

  always_comb begin
    in_ready_out = (cnt_r != DEPTH[AW:0]);
    wr = in_valid_in && in_ready_out;
    ld = (cnt_r != '0) && (!ov_r || out_ready_in);
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = ld ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, ld};
    ov_nxt = ld ? 1'b1 : (out_ready_in ? 1'b0 : ov_r);
    od_nxt = ld ? mem[rp_r] : od_r;
  end

  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem[wp_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  assign out_valid_out = ov_r;
  assign out_data_out = od_r;
  assign empty_out = !ov_r && (cnt_r == '0);
endmodule : tx_fifo

module modbus_rtu_slave_frame_handler
  import rtu_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter int FRAME_MAX = `FRAME_MAX
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [7:0] SLAVE_ADDR_IN,
  input wire logic READ_REPLY_COUNT_FORMAT_IN,
  input wire logic [7:0] RX_DATA_IN,
  input wire logic RX_VALID_IN,
  input wire logic RX_ERR_IN,
  output logic [7:0] TX_DATA_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  input wire logic TX_BUSY_IN,
  output logic DRIVER_EN_OUT,
  output logic [15:0] PAR_ADDR_OUT,
  output logic [15:0] PAR_WDATA_OUT,
  output logic PAR_WR_OUT,
  output logic PAR_RD_OUT,
  input wire logic [15:0] PAR_RDATA_IN,
  output logic FRAME_ERR_OUT
);
  // ---------------------------------------------------------------
  // crc step, shared by receive check and reply generation
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  localparam logic [5:0] ABORT_T = 6'(`GAP_ABORT_TICKS);
  localparam logic [5:0] FRAME_T = 6'(`GAP_FRAME_TICKS);

  state_t st_r, st_nxt;
  logic [11:0] bdiv_r, bdiv_nxt;
  logic [5:0] idle_r, idle_nxt, len_r, len_nxt, idx;
  logic [15:0] rcrc_r, rcrc_nxt, tcrc_r, tcrc_nxt;
  logic bad_r, bad_nxt, match_r, match_nxt, fmt_r, fmt_nxt, rd_mode_r;
  logic rd_mode_nxt, tick, take, fresh, good, bcast;
  logic [7:0] rbuf [FRAME_MAX];
  logic [15:0] words [`MAX_READ_WORDS];
  logic [5:0] eidx_r, eidx_nxt, elen_r, elen_nxt, hdr, k;
  logic [3:0] widx_r, widx_nxt, wcnt_r, wcnt_nxt;
  logic [15:0] padr_r, padr_nxt, pwd_r, pwd_nxt;
  logic pwr_r, pwr_nxt, prd_r, prd_nxt, err_r, err_nxt, drv_r, drv_nxt;
  logic [7:0] pbyte, cmd;
  logic push, f_ready, f_empty;

  // ---------------------------------------------------------------
  // bit timebase and line idle timer
  // ---------------------------------------------------------------
  always_comb begin
    tick = (bdiv_r == 12'(BIT_CYCLES - 1));
    bdiv_nxt = tick ? 12'h000 : bdiv_r + 12'h001;
    take = RX_VALID_IN && (st_r == S_IDLE);
    if (take || st_r == S_TXW) begin
      idle_nxt = 6'h00;
    end else if (tick && idle_r != FRAME_T) begin
      idle_nxt = idle_r + 6'h01;
    end else begin
      idle_nxt = idle_r;
    end
  end

  // ---------------------------------------------------------------
  // receive collection
  // ---------------------------------------------------------------
  always_comb begin
    fresh = (len_r == 6'h00) || (idle_r >= ABORT_T);
    idx = fresh ? 6'h00 : len_r;
    len_nxt = len_r;
    rcrc_nxt = rcrc_r;
    bad_nxt = bad_r;
    match_nxt = match_r;
    if (take) begin
      len_nxt = (idx == 6'(FRAME_MAX)) ? idx : idx + 6'h01;
      rcrc_nxt = crc_byte(fresh ? `CRC_SEED : rcrc_r, RX_DATA_IN);
      bad_nxt = (!fresh && bad_r) || RX_ERR_IN || (idx == 6'(FRAME_MAX));
      if (fresh) begin
        match_nxt = (RX_DATA_IN == `ADDR_BCAST) ||
                    (RX_DATA_IN == SLAVE_ADDR_IN &&
                     SLAVE_ADDR_IN <= `ADDR_LAST);
      end
    end else if (st_r == S_EVAL) begin
      len_nxt = 6'h00;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (take && idx != 6'(FRAME_MAX)) begin
      rbuf[idx[4:0]] <= RX_DATA_IN;
    end
    if (st_r == S_FCAP) begin
      words[widx_r] <= PAR_RDATA_IN;
    end
  end

  // ---------------------------------------------------------------
  // command decode and reply sequencer
  // ---------------------------------------------------------------
  always_comb begin
    cmd = rbuf[1];
    bcast = (rbuf[0] == `ADDR_BCAST);
    good = !bad_r && match_r && (rcrc_r == 16'h0000) &&
           (len_r >= 6'(`MIN_FRAME_LEN));
    hdr = fmt_r ? 6'h03 : 6'h04;
    k = eidx_r - hdr;
    st_nxt = st_r;
    eidx_nxt = eidx_r;
    elen_nxt = elen_r;
    tcrc_nxt = tcrc_r;
    widx_nxt = widx_r;
    wcnt_nxt = wcnt_r;
    fmt_nxt = fmt_r;
    rd_mode_nxt = rd_mode_r;
    padr_nxt = padr_r;
    pwd_nxt = pwd_r;
    pwr_nxt = 1'b0;
    prd_nxt = 1'b0;
    err_nxt = 1'b0;
    drv_nxt = drv_r;
    pbyte = 8'h00;
    push = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (len_r != 6'h00 && idle_r == FRAME_T) begin
          st_nxt = S_EVAL;
        end
      end
      S_EVAL: begin
        err_nxt = bad_r || (rcrc_r != 16'h0000) ||
                  (len_r < 6'(`MIN_FRAME_LEN));
        st_nxt = S_IDLE;
        eidx_nxt = 6'h00;
        tcrc_nxt = `CRC_SEED;
        fmt_nxt = READ_REPLY_COUNT_FORMAT_IN;
        widx_nxt = 4'h0;
        wcnt_nxt = rbuf[5][3:0];
        rd_mode_nxt = 1'b0;
        if (good && cmd == `CMD_READ && len_r == 6'(`REQ_LEN) &&
            rbuf[4] == 8'h00 && rbuf[5] != 8'h00 &&
            rbuf[5] <= 8'(`MAX_READ_WORDS) && !bcast) begin
          rd_mode_nxt = 1'b1;
          st_nxt = S_FETCH;
        end else if (good && cmd == `CMD_WRITE &&
                     len_r == 6'(`REQ_LEN)) begin
          padr_nxt = {rbuf[2], rbuf[3]};
          pwd_nxt = {rbuf[4], rbuf[5]};
          pwr_nxt = 1'b1;
          elen_nxt = 6'h06;
          st_nxt = bcast ? S_IDLE : S_EMIT;
        end else if (good && cmd == `CMD_LOOP && !bcast) begin
          elen_nxt = len_r - 6'h02;
          st_nxt = S_EMIT;
        end
      end
      S_FETCH: begin
        padr_nxt = {rbuf[2], rbuf[3]} + {12'h000, widx_r};
        prd_nxt = 1'b1;
        st_nxt = S_FWAIT;
      end
      S_FWAIT: begin
        st_nxt = S_FCAP;
      end
      S_FCAP: begin
        widx_nxt = widx_r + 4'h1;
        elen_nxt = hdr + {1'b0, wcnt_r, 1'b0};
        st_nxt = (widx_r + 4'h1 == wcnt_r) ? S_EMIT : S_FETCH;
      end
      S_EMIT: begin
        drv_nxt = 1'b1;
        if (eidx_r == elen_r) begin
          pbyte = tcrc_r[7:0];
        end else if (eidx_r == elen_r + 6'h01) begin
          pbyte = tcrc_r[15:8];
        end else if (!rd_mode_r || eidx_r < 6'h02) begin
          pbyte = rbuf[eidx_r[4:0]];
        end else if (eidx_r == 6'h02 && !fmt_r) begin
          pbyte = 8'h00;
        end else if (eidx_r < hdr) begin
          pbyte = {3'b000, wcnt_r, 1'b0};
        end else begin
          pbyte = k[0] ? words[k[4:1]][7:0] : words[k[4:1]][15:8];
        end
        push = f_ready;
        if (push) begin
          eidx_nxt = eidx_r + 6'h01;
          if (eidx_r < elen_r) begin
            tcrc_nxt = crc_byte(tcrc_r, pbyte);
          end
          if (eidx_r == elen_r + 6'h01) begin
            st_nxt = S_TXW;
          end
        end
      end
      S_TXW: begin
        if (f_empty && !TX_BUSY_IN) begin
          drv_nxt = 1'b0;
          st_nxt = S_GAP;
        end
      end
      S_GAP: begin
        if (idle_r == FRAME_T) begin
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
        drv_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_r <= S_IDLE;
      bdiv_r <= 12'h000;
      idle_r <= 6'h00;
      len_r <= 6'h00;
      rcrc_r <= `CRC_SEED;
      bad_r <= 1'b0;
      match_r <= 1'b0;
      tcrc_r <= `CRC_SEED;
      eidx_r <= 6'h00;
      elen_r <= 6'h00;
      widx_r <= 4'h0;
      wcnt_r <= 4'h0;
      fmt_r <= 1'b0;
      rd_mode_r <= 1'b0;
      padr_r <= 16'h0000;
      pwd_r <= 16'h0000;
      pwr_r <= 1'b0;
      prd_r <= 1'b0;
      err_r <= 1'b0;
      drv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bdiv_r <= bdiv_nxt;
      idle_r <= idle_nxt;
      len_r <= len_nxt;
      rcrc_r <= rcrc_nxt;
      bad_r <= bad_nxt;
      match_r <= match_nxt;
      tcrc_r <= tcrc_nxt;
      eidx_r <= eidx_nxt;
      elen_r <= elen_nxt;
      widx_r <= widx_nxt;
      wcnt_r <= wcnt_nxt;
      fmt_r <= fmt_nxt;
      rd_mode_r <= rd_mode_nxt;
      padr_r <= padr_nxt;
      pwd_r <= pwd_nxt;
      pwr_r <= pwr_nxt;
      prd_r <= prd_nxt;
      err_r <= err_nxt;
      drv_r <= drv_nxt;
    end
  end

  // reply bytes are staged so a slow uart does not stall the sequencer
  tx_fifo #(.W(8), .DEPTH(`TXF_DEPTH)) u_txf (
    .clk_in(CLK_IN),
    .rst_n_in(RESET_N_IN),
    .in_valid_in(push),
    .in_data_in(pbyte),
    .in_ready_out(f_ready),
    .out_valid_out(TX_VALID_OUT),
    .out_data_out(TX_DATA_OUT),
    .out_ready_in(TX_READY_IN),
    .empty_out(f_empty)
  );

  assign DRIVER_EN_OUT = drv_r;
  assign PAR_ADDR_OUT = padr_r;
  assign PAR_WDATA_OUT = pwd_r;
  assign PAR_WR_OUT = pwr_r;
  assign PAR_RD_OUT = prd_r;
  assign FRAME_ERR_OUT = err_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [4:0] nrd_r;
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      nrd_r <= 5'h00;
    end else if (st_r == S_EVAL) begin
      nrd_r <= 5'h00;
    end else if (prd_r) begin
      nrd_r <= nrd_r + 5'h01;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_abort_gap;
    take && len_r != 6'h00 && idle_r >= ABORT_T |=> len_r == 6'h01;
  endproperty
  a_abort_gap: assert property (p_abort_gap)
    else $error("partial frame not dropped after long gap");

  property p_eval_gap;
    st_r == S_EVAL |-> $past(idle_r) == FRAME_T;
  endproperty
  a_eval_gap: assert property (p_eval_gap)
    else $error("frame judged before full silence");

  property p_drive_tx;
    TX_VALID_OUT |-> DRIVER_EN_OUT && st_r != S_IDLE;
  endproperty
  a_drive_tx: assert property (p_drive_tx)
    else $error("byte offered while line not driven");

  property p_foreign;
    st_r == S_EVAL && !match_r |=> st_r == S_IDLE && !PAR_WR_OUT;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign frame acted upon");

  property p_bcast_write;
    st_r == S_EVAL && good && bcast && cmd == `CMD_WRITE &&
      len_r == 6'(`REQ_LEN) |=> PAR_WR_OUT ##1 st_r == S_IDLE;
  endproperty
  a_bcast_write: assert property (p_bcast_write)
    else $error("broadcast write not taken or answered");

  property p_read_limit;
    nrd_r <= 5'(`MAX_READ_WORDS);
  endproperty
  a_read_limit: assert property (p_read_limit)
    else $error("too many words fetched");

  property p_fmt0_count;
    push && rd_mode_r && !fmt_r && eidx_r == 6'h02 |-> pbyte == 8'h00;
  endproperty
  a_fmt0_count: assert property (p_fmt0_count)
    else $error("count high byte not zero");

  property p_crc_lo_first;
    push && eidx_r == elen_r |-> pbyte == tcrc_r[7:0]
      ##1 (st_r == S_EMIT && eidx_r == elen_r + 6'h01);
  endproperty
  a_crc_lo_first: assert property (p_crc_lo_first)
    else $error("crc byte order wrong");

  property p_crc_error;
    st_r == S_EVAL && len_r != 6'h00 && rcrc_r != 16'h0000
      |=> FRAME_ERR_OUT ##1 !FRAME_ERR_OUT;
  endproperty
  a_crc_error: assert property (p_crc_error)
    else $error("crc mismatch not flagged");

  property p_no_bad_reply;
    st_r == S_EVAL && (!good || bcast) |=> st_r != S_EMIT;
  endproperty
  a_no_bad_reply: assert property (p_no_bad_reply)
    else $error("reply started for rejected frame");

  c_read: cover property (st_r == S_FCAP && widx_r == 4'hB);
  c_write: cover property (st_r == S_EVAL && cmd == `CMD_WRITE
                           ##1 st_r == S_EMIT);
  c_loop: cover property (st_r == S_EMIT && !rd_mode_r && elen_r > 6'h06);
  c_err: cover property (FRAME_ERR_OUT);
endmodule : modbus_rtu_slave_frame_handler

// ---- tb/rtu_line_master.sv ----
// model of the line side: serial transmitter feeding the listening master
module rtu_line_master #(
  parameter int CHAR_CLK = 44
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic drv_en_in,
  input wire logic stall_in,
  output logic tx_ready_out,
  output logic tx_busy_out,
  output logic got_out,
  output logic [7:0] got_byte_out,
  output logic clash_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic phase;
  // a slow master takes a byte only every other cycle
  assign tx_ready_out = (cnt == 0) && !(stall_in && phase);
  assign tx_busy_out = (cnt != 0);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      phase <= 1'b0;
      got_out <= 1'b0;
      got_byte_out <= 8'h00;
      clash_out <= 1'b0;
    end else begin
      phase <= ~phase;
      got_out <= 1'b0;
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      if (tx_valid_in && tx_ready_out) begin
        // eleven bit times per char, doubled when stalling
        cnt <= stall_in ? 2 * CHAR_CLK : CHAR_CLK;
        got_out <= 1'b1;
        got_byte_out <= tx_data_in;
        if (!drv_en_in) begin
          clash_out <= 1'b1;
        end
      end
    end
  end
endmodule : rtu_line_master

// ---- tb/tb.sv ----
// self-checking bench of the rtu slave frame handler
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] byte_q_t[$];
  localparam int BITC = 4;
  localparam int CHR = 11 * BITC;
  logic clk = 1'b0, rst_n = 1'b0, fmt = 1'b0, stall = 1'b0;
  logic [7:0] slave_addr = 8'h01, rx_data = 8'h00, tx_data, got_byte;
  logic rx_valid = 1'b0, rx_err = 1'b0, tx_valid, tx_ready, tx_busy;
  logic drv_en, par_wr, par_rd, frame_err, got, clash;
  logic [15:0] par_addr, par_wdata, par_rdata = 16'h0000;
  logic [15:0] wr_addr, wr_data;
  int n_errors = 0, cmp_count = 0, n_ferr = 0, f0 = 0, wr_cnt = 0;
  byte_q_t rx_q, none;

  always #25 clk = ~clk;

  modbus_rtu_slave_frame_handler #(.BIT_CYCLES(BITC)) uut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .SLAVE_ADDR_IN(slave_addr),
    .READ_REPLY_COUNT_FORMAT_IN(fmt), .RX_DATA_IN(rx_data),
    .RX_VALID_IN(rx_valid), .RX_ERR_IN(rx_err), .TX_DATA_OUT(tx_data),
    .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
    .TX_BUSY_IN(tx_busy), .DRIVER_EN_OUT(drv_en),
    .PAR_ADDR_OUT(par_addr), .PAR_WDATA_OUT(par_wdata),
    .PAR_WR_OUT(par_wr), .PAR_RD_OUT(par_rd),
    .PAR_RDATA_IN(par_rdata), .FRAME_ERR_OUT(frame_err));

  rtu_line_master #(.CHAR_CLK(CHR)) master (
    .clk_in(clk), .rst_n_in(rst_n), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .drv_en_in(drv_en), .stall_in(stall),
    .tx_ready_out(tx_ready), .tx_busy_out(tx_busy), .got_out(got),
    .got_byte_out(got_byte), .clash_out(clash));

  // -------------------------------------------------------------
  // parameter store and line monitors
  // -------------------------------------------------------------
  // data derived from address so misordered fetches show up
  always @(negedge clk) begin
    if (par_rd === 1'b1) par_rdata <= par_addr ^ 16'h5A3C;
  end
  always @(posedge clk) begin
    if (got === 1'b1) rx_q.push_back(got_byte);
    if (frame_err === 1'b1) n_ferr++;
    if (par_wr === 1'b1) begin
      wr_cnt++;
      wr_addr = par_addr;
      wr_data = par_wdata;
    end
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic byte_q_t with_crc(input byte_q_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction : with_crc

  task automatic chk16(input logic [15:0] got_v, input logic [15:0] exp);
    cmp_count++;
    if (got_v !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got_v, exp);
    end
  endtask : chk16

  task automatic put_byte(input logic [7:0] b, input logic e, input int gap);
    @(negedge clk);
    rx_data = b;
    rx_valid = 1'b1;
    rx_err = e;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_err = 1'b0;
    repeat (gap - 1) @(negedge clk);
  endtask : put_byte

  // bad flips crc high byte, pe marks one byte with a parity fault
  task automatic send(input byte_q_t q, input logic [7:0] bad, input int pe);
    q = with_crc(q);
    q[q.size() - 1] ^= bad;
    rx_q.delete();
    f0 = n_ferr;
    foreach (q[i]) put_byte(q[i], i == pe, CHR);
  endtask : send

  task automatic await_reply(input string name, input byte_q_t exp,
                             input logic [15:0] errs);
    int n;
    n = 0;
    while (drv_en !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (drv_en !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    // master keeps silent past the frame gap before its next request
    repeat (200) @(negedge clk);
    chk16(16'(n_ferr - f0), errs);
    chk16(16'(rx_q.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < rx_q.size()) chk16({8'h00, rx_q[i]}, {8'h00, exp[i]});
    end
    $display("test %s done", name);
  endtask : await_reply

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_read(input logic f, input logic [15:0] st,
                        input logic [7:0] n);
    byte_q_t req, exp;
    logic [15:0] w;
    fmt = f;
    req = '{slave_addr, 8'h03, st[15:8], st[7:0], 8'h00, n};
    exp = '{slave_addr, 8'h03};
    if (!f) exp.push_back(8'h00);
    exp.push_back({n[6:0], 1'b0});
    for (int i = 0; i < n; i++) begin
      w = (st + 16'(i)) ^ 16'h5A3C;
      exp.push_back(w[15:8]);
      exp.push_back(w[7:0]);
    end
    send(req, 8'h00, -1);
    await_reply("read", with_crc(exp), 16'h0000);
  endtask : t_read

  task automatic t_write(input logic [7:0] a, input logic [15:0] pa,
                         input logic [15:0] v);
    byte_q_t req;
    int w0;
    req = '{a, 8'h06, pa[15:8], pa[7:0], v[15:8], v[7:0]};
    w0 = wr_cnt;
    send(req, 8'h00, -1);
    if (a == 8'h00) await_reply("bcast write", none, 16'h0000);
    else await_reply("write", with_crc(req), 16'h0000);
    chk16(16'(wr_cnt - w0), 16'h0001);
    chk16(wr_addr, pa);
    chk16(wr_data, v);
  endtask : t_write

  task automatic t_quiet(input string name, input byte_q_t req,
                         input logic [7:0] bad, input int pe,
                         input logic [15:0] errs);
    send(req, bad, pe);
    await_reply(name, none, errs);
  endtask : t_quiet

  task automatic t_merge;
    byte_q_t req;
    int w0;
    req = '{slave_addr, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01};
    w0 = wr_cnt;
    send(req, 8'h00, -1);
    req = with_crc(req);
    foreach (req[i]) put_byte(req[i], 1'b0, CHR);
    await_reply("merge", none, 16'h0001);
    chk16(16'(wr_cnt - w0), 16'h0000);
  endtask : t_merge

  task automatic t_loop;
    byte_q_t req;
    req = '{slave_addr, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    send(req, 8'h00, -1);
    await_reply("loop", with_crc(req), 16'h0000);
  endtask : t_loop

  // partial frame then a pause past 1.5 chars but short of 3.5
  task automatic t_abort;
    put_byte(slave_addr, 1'b0, CHR);
    put_byte(8'h03, 1'b0, 20 * BITC);
    t_read(1'b1, 16'h0200, 8'd1);
  endtask : t_abort

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_read(1'b0, 16'hF002, 8'd2);
    stall = 1'b1;
    t_read(1'b1, 16'hF000, 8'd12);
    stall = 1'b0;
    t_write(slave_addr, 16'hF00A, 16'h1388);
    t_write(8'h00, 16'h0102, 16'hBEEF);
    t_loop();
    t_quiet("foreign", '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
            8'h00, -1, 16'h0000);
    t_quiet("bad crc", '{slave_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
            8'h01, -1, 16'h0001);
    t_quiet("parity", '{slave_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
            8'h00, 2, 16'h0001);
    t_quiet("unknown", '{slave_addr, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01},
            8'h00, -1, 16'h0000);
    t_quiet("bcast read", '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
            8'h00, -1, 16'h0000);
    t_abort();
    t_merge();
    slave_addr = 8'hF7;
    t_read(1'b0, 16'h1000, 8'd1);
    chk16({15'h0000, clash}, 16'h0000);
    complete_run();
  end
endmodule : tb
